// ===== src/mifl_consts.vh
// Constants for the interrupt flag, mask and vectoring block.
// Assumes a single 100 MHz clock and an instruction cycle enable from the core side.
`ifndef MIFL_CONSTS_VH
`define MIFL_CONSTS_VH

// Register offsets on the plain register port.
`define MIFL_ADDR_W 8
`define MIFL_OFS_CONTROL 8'h0B
`define MIFL_OFS_CONTROL_HI 8'h8B
`define MIFL_OFS_PFLAGS 8'h0C
`define MIFL_OFS_PENABLES 8'h8C
`define MIFL_OFS_OPTION 8'h81

// Control register fields.
`define MIFL_CTL_GIE 7
`define MIFL_CTL_PERIPHERAL_GROUP_ENABLE 6
`define MIFL_CTL_TICK_OVERFLOW_ENABLE 5
`define MIFL_CTL_EXT_PIN_ENABLE 4
`define MIFL_CTL_PORT_CHANGE_ENABLE 3
`define MIFL_CTL_TICK_OVERFLOW_FLAG 2
`define MIFL_CTL_EXT_PIN_FLAG 1
`define MIFL_CTL_PORT_CHANGE_FLAG 0

// Peripheral flag and enable fields.
`define MIFL_PF_EE 7
`define MIFL_PF_AD 6
`define MIFL_PF_CM 3
`define MIFL_PF_T1 0
`define MIFL_PF_MASK 8'hC9

// Option register edge select bit.
`define MIFL_OPT_EDGE 6

// Reset values.
`define MIFL_RST_CONTROL 8'h00
`define MIFL_RST_PFLAGS 8'h00
`define MIFL_RST_PENABLES 8'h00
`define MIFL_RST_OPTION 8'hFF

// Vector address and sampling pipeline depth, in instruction cycles.
`define MIFL_VECTOR 13'h0004
`define MIFL_PC_W 13
`define MIFL_LAT_STAGES 2

`endif

// ===== src/mifl_edge_det.v
// Edge detector for the external interrupt pin with selectable polarity.
// Assumes the pin is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module mifl_edge_det (
    input wire clk_i,
    input wire nrst_i,
    input wire pin_i,
    input wire rising_i,
    output reg edge_o
);
    reg pin_q;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_q <= 1'b0;
            edge_o <= 1'b0;
        end else begin
            pin_q <= pin_i;
            // A polarity change alone makes no edge; both terms need pin_i to differ from pin_q.
            edge_o <= rising_i ? (pin_i & ~pin_q) : (~pin_i & pin_q);
        end
    end
endmodule // mifl_edge_det
`default_nettype wire

// ===== src/mifl_req_pipe.v
// Request sampling pipeline counted in instruction cycles.
// Assumes cyc_en_i pulses once per instruction cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mifl_consts.vh"
module mifl_req_pipe (
    input wire clk_i,
    input wire nrst_i,
    input wire cyc_en_i,
    input wire req_i,
    output wire req_o
);
    reg [`MIFL_LAT_STAGES-1:0] stage;

    // Two stages give the three to four cycle latency once the vector cycle is added.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage <= {`MIFL_LAT_STAGES{1'b0}};
        end else if (cyc_en_i) begin
            stage <= {stage[`MIFL_LAT_STAGES-2:0], req_i};
        end
    end

    assign req_o = stage[`MIFL_LAT_STAGES-1] & req_i;
endmodule // mifl_req_pipe
`default_nettype wire

// ===== src/mifl_top.v
// Interrupt flag, mask and vectoring logic of a small 8-bit controller.
// Assumes the core gives an instruction cycle enable and pulses for instruction events.
//
// Contract
// - Seven interrupt sources: pin edge, tick, port change, comparator, converter, timer, nv write.
// - Control bit 7 is global enable; set passes unmasked requests, clear blocks all.
// - Every source has its own enable bit; clear enable blocks that source.
// - Any reset clears the global enable bit.
// - Return-from-handler instruction sets the global enable again.
// - Pin, port change and tick flags live in the control register.
// - Four peripheral flags in peripheral flag register, enables in enable register.
// - Peripheral flags: nv write bit 7, converter bit 6, comparator bit 3, timer bit 0.
// - Accepting an interrupt clears global enable, pushes return address, vectors to 0004h.
// - External event latency to vector is three or four instruction cycles when awake; in sleep it vectors at the next cycle enable.
// - Flags set on their event regardless of any enable bit.
// - Requests blocked by clearing global enable stay pending until re-enabled.
// - Interrupt wake with global enable vectors to 0004h, otherwise continues next address.
// - Wake from sleep sets only the causing source flags.
// - Pin edge sets control bit 1; edge select bit chooses rising or falling.
// - Tick wrap FFh to 00h sets control bit 2; enabled by control bit 5.
// - Port change sets control bit 0; enabled by control bit 3.
`timescale 1ns/1ps
`default_nettype none
`include "mifl_consts.vh"
module mifl_top (
    input wire clk_i,
    input wire nrst_i,
    input wire cyc_en_i,
    input wire [`MIFL_ADDR_W-1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire ext_irq_pin_i,
    input wire tick_wrap_i,
    input wire port_change_i,
    input wire comparator_change_i,
    input wire conv_done_i,
    input wire timer_one_roll_i,
    input wire nv_write_done_i,
    input wire sleeping_i,
    input wire [`MIFL_PC_W-1:0] next_pc_i,
    input wire global_clear_instr_i,
    input wire return_from_handler_instr_i,
    output reg vector_o,
    output reg [`MIFL_PC_W-1:0] vector_addr_o,
    output reg push_o,
    output reg [`MIFL_PC_W-1:0] push_addr_o,
    output reg wake_o,
    output reg irq_pending_o
);
    reg [7:0] irq_control_reg;
    reg [7:0] peripheral_flag_reg;
    reg [7:0] peripheral_enable_reg;
    reg [7:0] option_reg;
    reg [7:0] next_control;
    reg [7:0] next_pflags;
    reg [7:0] ctl_set;
    reg [7:0] pf_set;
    reg gie_block;
    reg [7:0] read_mux;
    wire ext_edge;
    wire global_irq_enable;
    wire peripheral_group_enable;
    wire ctl_hit;
    wire pf_hit;
    wire pe_hit;
    wire opt_hit;
    wire core_any;
    wire periph_any;
    wire source_any;
    wire masked_req;
    wire accepted_req;
    wire accept;
    wire sleep_vec;

    assign global_irq_enable = irq_control_reg[`MIFL_CTL_GIE];
    assign peripheral_group_enable = irq_control_reg[`MIFL_CTL_PERIPHERAL_GROUP_ENABLE];
    assign ctl_hit = (addr_i == `MIFL_OFS_CONTROL) || (addr_i == `MIFL_OFS_CONTROL_HI);
    assign pf_hit = (addr_i == `MIFL_OFS_PFLAGS);
    assign pe_hit = (addr_i == `MIFL_OFS_PENABLES);
    assign opt_hit = (addr_i == `MIFL_OFS_OPTION);

    mifl_edge_det u_edge (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(ext_irq_pin_i),
        .rising_i(option_reg[`MIFL_OPT_EDGE]),
        .edge_o(ext_edge)
    );

    // Event set vectors; flags set whatever the enables say.
    always @* begin
        ctl_set = 8'h00;
        ctl_set[`MIFL_CTL_EXT_PIN_FLAG] = ext_edge;
        ctl_set[`MIFL_CTL_TICK_OVERFLOW_FLAG] = tick_wrap_i;
        ctl_set[`MIFL_CTL_PORT_CHANGE_FLAG] = port_change_i;
        pf_set = 8'h00;
        pf_set[`MIFL_PF_EE] = nv_write_done_i;
        pf_set[`MIFL_PF_AD] = conv_done_i;
        pf_set[`MIFL_PF_CM] = comparator_change_i;
        pf_set[`MIFL_PF_T1] = timer_one_roll_i;
    end

    // Per-source masking of the three core sources and the peripheral group.
    assign core_any = (irq_control_reg[`MIFL_CTL_EXT_PIN_FLAG] & irq_control_reg[`MIFL_CTL_EXT_PIN_ENABLE]) |
        (irq_control_reg[`MIFL_CTL_TICK_OVERFLOW_FLAG] & irq_control_reg[`MIFL_CTL_TICK_OVERFLOW_ENABLE]) |
        (irq_control_reg[`MIFL_CTL_PORT_CHANGE_FLAG] & irq_control_reg[`MIFL_CTL_PORT_CHANGE_ENABLE]);
    assign periph_any = peripheral_group_enable &
        (|(peripheral_flag_reg & peripheral_enable_reg & `MIFL_PF_MASK));
    assign source_any = core_any | periph_any;
    // Gating by the global enable comes last, so blocked requests stay pending.
    assign masked_req = source_any & global_irq_enable & ~gie_block;

    mifl_req_pipe u_pipe (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .cyc_en_i(cyc_en_i),
        .req_i(masked_req),
        .req_o(accepted_req)
    );

    assign accept = cyc_en_i & accepted_req & ~sleeping_i;
    // A vector taken out of sleep is an accepted interrupt too, so it drops the global enable.
    assign sleep_vec = sleeping_i & source_any & cyc_en_i & global_irq_enable;

    // Next value of the control register: write, then hardware sets win over clears.
    always @* begin
        next_control = irq_control_reg;
        next_pflags = peripheral_flag_reg;
        if (wr_i && ctl_hit) begin
            next_control = wdata_i;
        end
        if (wr_i && pf_hit) begin
            next_pflags = wdata_i & `MIFL_PF_MASK;
        end
        if (global_clear_instr_i) begin
            next_control[`MIFL_CTL_GIE] = 1'b0;
        end
        if (return_from_handler_instr_i) begin
            next_control[`MIFL_CTL_GIE] = 1'b1;
        end
        if (accept || sleep_vec) begin
            next_control[`MIFL_CTL_GIE] = 1'b0;
        end
        next_control = next_control | ctl_set;
        next_pflags = next_pflags | pf_set;
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_control_reg <= `MIFL_RST_CONTROL;
            peripheral_flag_reg <= `MIFL_RST_PFLAGS;
            peripheral_enable_reg <= `MIFL_RST_PENABLES;
            option_reg <= `MIFL_RST_OPTION;
            gie_block <= 1'b0;
        end else begin
            irq_control_reg <= next_control;
            peripheral_flag_reg <= next_pflags;
            if (wr_i && pe_hit) begin
                peripheral_enable_reg <= wdata_i & `MIFL_PF_MASK;
            end
            if (wr_i && opt_hit) begin
                option_reg <= wdata_i;
            end
            // The cycle after a global clear ignores requests; they remain pending.
            if (cyc_en_i || global_clear_instr_i) begin
                gie_block <= global_clear_instr_i;
            end
        end
    end

    always @* begin
        read_mux = 8'h00;
        if (ctl_hit) begin
            read_mux = irq_control_reg;
        end else if (pf_hit) begin
            read_mux = peripheral_flag_reg;
        end else if (pe_hit) begin
            read_mux = peripheral_enable_reg;
        end else if (opt_hit) begin
            read_mux = option_reg;
        end
    end

    // Core-facing outputs, all registered.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
            vector_o <= 1'b0;
            vector_addr_o <= {`MIFL_PC_W{1'b0}};
            push_o <= 1'b0;
            push_addr_o <= {`MIFL_PC_W{1'b0}};
            wake_o <= 1'b0;
            irq_pending_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? read_mux : 8'h00;
            irq_pending_o <= source_any;
            // Wake needs only source enables; the global enable decides vector or next.
            wake_o <= sleeping_i & source_any;
            vector_o <= 1'b0;
            push_o <= 1'b0;
            if (accept) begin
                vector_o <= 1'b1;
                vector_addr_o <= `MIFL_VECTOR;
                push_o <= 1'b1;
                push_addr_o <= next_pc_i;
            end else if (sleeping_i && source_any && cyc_en_i) begin
                if (global_irq_enable) begin
                    vector_o <= 1'b1;
                    vector_addr_o <= `MIFL_VECTOR;
                    push_o <= 1'b1;
                    push_addr_o <= next_pc_i;
                end
            end
        end
    end
endmodule // mifl_top
`default_nettype wire

// ===== tb/mifl_checker.sv
// Port checker for the interrupt flag block, bound to its top module.
// Assumes the single clock domain and the active low reset of the top.
`timescale 1ns/1ps
`default_nettype none
`include "mifl_consts.vh"
module mifl_checker (
    input wire clk_i,
    input wire nrst_i,
    input wire cyc_en_i,
    input wire [7:0] addr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire sleeping_i,
    input wire vector_o,
    input wire [12:0] vector_addr_o,
    input wire push_o,
    input wire wake_o,
    input wire irq_pending_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    vec_addr_a: assert property (vector_o |-> vector_addr_o == `MIFL_VECTOR)
        else $error("vector address wrong");
    push_pair_a: assert property (push_o == vector_o)
        else $error("push and vector differ");
    vec_pulse_a: assert property (vector_o |=> !vector_o)
        else $error("vector longer than one cycle");
    vec_cycle_a: assert property (vector_o |-> $past(cyc_en_i))
        else $error("vector not after cycle enable");
    vec_cause_a: assert property (vector_o |-> $past(irq_pending_o))
        else $error("vector without pending source");
    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    pflag_bits_a: assert property ($past(rd_i) && $past(addr_i) == `MIFL_OFS_PFLAGS
        |-> (rdata_o & 8'h36) == 8'h00)
        else $error("unused flag bit reads one");
    wake_sleep_a: assert property (wake_o |-> $past(sleeping_i))
        else $error("wake while awake");
    cover property (vector_o);
    cover property (wake_o);
    cover property (wake_o && vector_o);
endmodule // mifl_checker
bind mifl_top mifl_checker chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .cyc_en_i(cyc_en_i),
    .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleeping_i(sleeping_i),
    .vector_o(vector_o), .vector_addr_o(vector_addr_o), .push_o(push_o),
    .wake_o(wake_o), .irq_pending_o(irq_pending_o));
`default_nettype wire

// ===== tb/mifl_core_model.sv
// Core-side partner: instruction cycle enable, return address, sleep state.
// Assumes one clock; the core leaves sleep as soon as the block signals wake.
`timescale 1ns/1ps
`default_nettype none
module mifl_core_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic go_sleep_i,
    input wire logic wake_i,
    output logic cyc_en_o,
    output logic [12:0] pc_o,
    output logic sleeping_o
);
    logic [1:0] phase;
    // Four clocks per instruction cycle, so the enable is never two edges in a row.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase <= 2'h0;
            cyc_en_o <= 1'b0;
            pc_o <= 13'h0000;
            sleeping_o <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            cyc_en_o <= (phase == 2'h3);
            if (cyc_en_o) begin
                pc_o <= pc_o + 13'h0001;
            end
            if (go_sleep_i) begin
                sleeping_o <= 1'b1;
            end else if (wake_i) begin
                sleeping_o <= 1'b0;
            end
        end
    end
endmodule // mifl_core_model
`default_nettype wire

// ===== tb/testbench.sv
// Testbench for the interrupt flag block: registers, vectoring, masking, sleep.
// Assumes the core model supplies cycle enable, return address and sleep state.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, pin = 0, cyc_en, sleeping;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
    logic [8:0] evt = 9'h000;
    logic vector_o, push_o, wake_o, pend, seen;
    logic [12:0] pc, vaddr, paddr;
    int err_count = 0, check_count = 0, ncyc;
    always #5 clk_i = ~clk_i;
    mifl_core_model core (.clk_i(clk_i), .nrst_i(nrst_i), .go_sleep_i(evt[6]),
        .wake_i(wake_o), .cyc_en_o(cyc_en), .pc_o(pc), .sleeping_o(sleeping));
    // Event bit 8 stands for the instruction that clears the global enable.
    mifl_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .cyc_en_i(cyc_en), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ext_irq_pin_i(pin), .tick_wrap_i(evt[0]), .port_change_i(evt[1]),
        .comparator_change_i(evt[2]), .conv_done_i(evt[3]), .timer_one_roll_i(evt[4]),
        .nv_write_done_i(evt[5]), .sleeping_i(sleeping), .next_pc_i(pc),
        .global_clear_instr_i(evt[8]), .return_from_handler_instr_i(evt[7]),
        .vector_o(vector_o), .vector_addr_o(vaddr), .push_o(push_o),
        .push_addr_o(paddr), .wake_o(wake_o), .irq_pending_o(pend));
    task automatic chk(input string nm, input logic [12:0] exp, got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", {5'h00, exp}, {5'h00, rdata_o});
    endtask
    task automatic pulse(input int i);
        @(posedge clk_i);
        evt <= 9'h001 << i;
        @(posedge clk_i);
        evt <= 9'h000;
    endtask
    // Counts instruction cycles from the flag edge until the vector shows.
    task automatic wait_vec(input logic exp, lat);
        seen = 0;
        ncyc = 0;
        repeat (40) begin
            #1;
            if (vector_o === 1'b1) seen = 1;
            if (!seen && cyc_en === 1'b1) ncyc++;
            @(posedge clk_i);
        end
        chk("vector", {12'h000, exp}, {12'h000, seen});
        if (lat) chk("latency", 13'h0001, {12'h000, ncyc == 3 || ncyc == 4});
    endtask
    task automatic t_reset();
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h00);
        rd(8'h8C, 8'h00);
        rd(8'h81, 8'hFF);
        rd(8'h40, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_flags();
        for (int i = 0; i < 6; i++) pulse(i);
        pin <= 1'b1;
        wait_vec(1'b0, 1'b0);
        rd(8'h0B, 8'h07);
        rd(8'h0C, 8'hC9);
        wr(8'h0C, 8'h00);
        wr(8'h0B, 8'h00);
        wr(8'h8C, 8'hFF);
        rd(8'h8C, 8'hC9);
        wr(8'h81, 8'hBF);
        pin <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(8'h0B, 8'h02);
        $display("test flags done");
    endtask
    task automatic t_vector();
        wr(8'h0B, 8'h88);
        pulse(1);
        wait_vec(1'b1, 1'b1);
        rd(8'h0B, 8'h09);
        chk("pending", 13'h0001, {12'h000, pend});
        wr(8'h0B, 8'h08);
        pulse(7);
        rd(8'h0B, 8'h88);
        wr(8'h0B, 8'h80);
        pulse(1);
        wait_vec(1'b0, 1'b0);
        wr(8'h0B, 8'h08);
        pulse(1);
        wait_vec(1'b0, 1'b0);
        wr(8'h0B, 8'h89);
        wait_vec(1'b1, 1'b0);
        wr(8'h8C, 8'h40);
        wr(8'h0B, 8'h80);
        pulse(3);
        wait_vec(1'b0, 1'b0);
        wr(8'h0B, 8'hC0);
        wait_vec(1'b1, 1'b0);
        wr(8'h0C, 8'h00);
        wr(8'h0B, 8'h88);
        pulse(8);
        rd(8'h0B, 8'h08);
        pulse(1);
        wait_vec(1'b0, 1'b0);
        pulse(7);
        wait_vec(1'b1, 1'b0);
        $display("test vector done");
    endtask
    task automatic t_sleep();
        wr(8'h0B, 8'h08);
        pulse(6);
        pulse(1);
        wait_vec(1'b0, 1'b0);
        chk("asleep", 13'h0000, {12'h000, sleeping});
        rd(8'h0B, 8'h09);
        rd(8'h0C, 8'h00);
        wr(8'h0B, 8'h88);
        pulse(6);
        pulse(1);
        wait_vec(1'b1, 1'b0);
        $display("test sleep done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_flags();
        t_vector();
        t_sleep();
        test_done();
    end
    // The tests need about 550 clocks; the 20000-clock limit is over thirty times that and means a hang.
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule // testbench
`default_nettype wire
